// file: logic/ssc_top.sv
// Semaphore control for a serial slave shared buffer, with APB registers
// Summary of operation
// - Processor taking semaphore sets event; writing zero clears
// - Shortcut bit acquires semaphore on every end
// - Enable-set write one enables that event interrupt
// - Enable-clear write one disables that event interrupt
// - State reads free 0, processor 1, slave 2
// - State 3: slave holds, processor handover pending
// - Processor owns semaphore out of reset
// - Independent enables, all disabled at reset
// - Release task frees processor's semaphore hold
//
// The APB slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module ssc_top
    import ssc_pkg::*;
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    // Serial link from the external master
    input  wire logic        sck,
    input  wire logic        csn_n,
    input  wire logic        mosi,
    // Interrupt
    output var  logic        irq
);

    // Synchronised link pins
    logic [2:0] pins_s;
    logic       sck_s;
    logic       csn_s_n;
    logic       sck_prev_q;
    logic       csn_prev_q;
    logic       frame_start;
    logic       frame_stop;
    logic       sck_rise;

    ssc_sync #(
        .W (3)
    ) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       ({mosi, ~csn_n, sck}),
        .q       (pins_s)
    );

    assign sck_s   = pins_s[0];
    // Select is synchronised active high so the reset value 0 means deselected
    assign csn_s_n = !pins_s[1];

    // Edge finders; reset to idle levels so no false edge after reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sck_prev_q <= 1'b0;
            csn_prev_q <= 1'b1;
        end else begin
            sck_prev_q <= sck_s;
            csn_prev_q <= csn_s_n;
        end
    end

    assign frame_start = csn_prev_q && !csn_s_n;
    assign frame_stop  = !csn_prev_q && csn_s_n;
    assign sck_rise    = !sck_prev_q && sck_s && !csn_s_n;

    // APB decode; writes take effect at the edge with pready high, read data is sampled one edge earlier
    logic        access;
    logic        wr_en;
    logic        rd_hit;
    logic        mapped;
    logic [31:0] rd_val;
    logic        short_q;
    logic [1:0]  sem_code;
    logic [EVT_N-1:0] irq_en_q;
    logic [EVT_N-1:0] evt_q;

    assign access = psel && penable && pready;
    assign wr_en  = access && pwrite;

    always_comb begin
        mapped = 1'b1;
        rd_val = 32'h0000_0000;
        unique case (paddr)
            OFS_TASK_ACQUIRE: rd_val = 32'h0000_0000;
            OFS_TASK_RELEASE: rd_val = 32'h0000_0000;
            OFS_EVT_END:      rd_val = {31'h0, evt_q[EVT_END_BIT]};
            OFS_EVT_RXFULL:   rd_val = {31'h0, evt_q[EVT_RXFULL_BIT]};
            OFS_EVT_TAKEN:    rd_val = {31'h0, evt_q[EVT_TAKEN_BIT]};
            OFS_SHORTCUT:     rd_val = {31'h0, short_q};
            OFS_IRQ_EN_SET:   rd_val = {29'h0, irq_en_q};
            OFS_IRQ_EN_CLR:   rd_val = {29'h0, irq_en_q};
            OFS_SEM_STATE:    rd_val = {30'h0, sem_code};
            OFS_IRQ_STATUS:   rd_val = {29'h0, evt_q};
            OFS_IRQ_CLEAR:    rd_val = 32'h0000_0000;
            default:          mapped = 1'b0;
        endcase
    end

    assign rd_hit = psel && penable && !pready;

    // One wait state: pready rises in the second access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= rd_hit;
            pslverr <= rd_hit && !mapped;
            // Writes load zero so a refused write never shows stale read data
            if (rd_hit) begin
                prdata <= pwrite ? 32'h0000_0000 : rd_val;
            end else if (!psel) begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // Task strobes
    logic wr_acquire;
    logic wr_release;

    assign wr_acquire = wr_en && (paddr == OFS_TASK_ACQUIRE) && pwdata[TASK_BIT];
    assign wr_release = wr_en && (paddr == OFS_TASK_RELEASE) && pwdata[TASK_BIT];

    // Shortcut control
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            short_q <= SHORT_RESET;
        end else if (wr_en && paddr == OFS_SHORTCUT) begin
            short_q <= pwdata[SHORT_END_ACQ_BIT];
        end
    end

    // Interrupt enables
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_en_q <= IRQ_EN_RESET;
        end else if (wr_en && paddr == OFS_IRQ_EN_SET) begin
            irq_en_q <= irq_en_q | pwdata[EVT_N-1:0];
        end else if (wr_en && paddr == OFS_IRQ_EN_CLR) begin
            irq_en_q <= irq_en_q & ~pwdata[EVT_N-1:0];
        end
    end

    // Semaphore ownership
    ssc_sem_type sem_q;
    logic        granted_q;
    logic        end_evt;
    logic        acq_req;
    logic        taken_evt;

    assign end_evt = frame_stop && granted_q;
    assign acq_req = wr_acquire || (end_evt && short_q);

    // Slave end of transfer releases first, then any acquire is served
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sem_q <= SSC_CPU;
        end else begin
            unique case (sem_q)
                SSC_FREE: begin
                    if (acq_req) begin
                        sem_q <= SSC_CPU;
                    end else if (frame_start) begin
                        sem_q <= SSC_SLAVE;
                    end
                end
                SSC_CPU: begin
                    if (wr_release) begin
                        sem_q <= SSC_FREE;
                    end
                end
                SSC_SLAVE: begin
                    if (end_evt && acq_req) begin
                        sem_q <= SSC_CPU;
                    end else if (end_evt) begin
                        sem_q <= SSC_FREE;
                    end else if (acq_req) begin
                        sem_q <= SSC_PEND;
                    end
                end
                SSC_PEND: begin
                    if (end_evt) begin
                        sem_q <= SSC_CPU;
                    end
                end
            endcase
        end
    end

    // Processor obtains the semaphore
    always_comb begin
        taken_evt = 1'b0;
        unique case (sem_q)
            SSC_FREE:  taken_evt = acq_req;
            SSC_CPU:   taken_evt = 1'b0;
            SSC_SLAVE: taken_evt = end_evt && acq_req;
            SSC_PEND:  taken_evt = end_evt;
        endcase
    end

    always_comb begin
        unique case (sem_q)
            SSC_FREE:  sem_code = SEM_CODE_FREE;
            SSC_CPU:   sem_code = SEM_CODE_CPU;
            SSC_SLAVE: sem_code = SEM_CODE_SLAVE;
            SSC_PEND:  sem_code = SEM_CODE_PEND;
        endcase
    end

    // A frame is granted only if the semaphore is free when it opens
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            granted_q <= 1'b0;
        end else if (frame_start) begin
            granted_q <= (sem_q == SSC_FREE) && !acq_req;
        end else if (frame_stop) begin
            granted_q <= 1'b0;
        end
    end

    // Receive byte counting; the buffer fills once per granted frame
    logic [2:0] bit_cnt_q;
    logic [7:0] byte_cnt_q;
    logic       rx_full_evt;

    assign rx_full_evt = granted_q && sck_rise && (bit_cnt_q == BITS_LAST)
                         && (byte_cnt_q == RX_BUF_BYTES - 8'h01);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bit_cnt_q  <= 3'h0;
            byte_cnt_q <= 8'h00;
        end else if (frame_start) begin
            bit_cnt_q  <= 3'h0;
            byte_cnt_q <= 8'h00;
        end else if (granted_q && sck_rise && byte_cnt_q != RX_BUF_BYTES) begin
            bit_cnt_q <= bit_cnt_q + 3'h1;
            if (bit_cnt_q == BITS_LAST) begin
                byte_cnt_q <= byte_cnt_q + 8'h01;
            end
        end
    end

    // Event flags: cleared by writing 0 to their own register or 1 to the clear register
    logic [EVT_N-1:0] evt_set;
    logic [EVT_N-1:0] evt_clr;
    logic [11:0]      evt_ofs [EVT_N];

    assign evt_set[EVT_END_BIT]    = end_evt;
    assign evt_set[EVT_RXFULL_BIT] = rx_full_evt;
    assign evt_set[EVT_TAKEN_BIT]  = taken_evt;
    assign evt_ofs[EVT_END_BIT]    = OFS_EVT_END;
    assign evt_ofs[EVT_RXFULL_BIT] = OFS_EVT_RXFULL;
    assign evt_ofs[EVT_TAKEN_BIT]  = OFS_EVT_TAKEN;

    for (genvar i = 0; i < EVT_N; i++) begin : g_evt
        assign evt_clr[i] = wr_en && ((paddr == evt_ofs[i] && !pwdata[0])
                            || (paddr == OFS_IRQ_CLEAR && pwdata[i]));
        ssc_evt u_evt (
            .pclk    (pclk),
            .presetn (presetn),
            .set     (evt_set[i]),
            .clr     (evt_clr[i]),
            .flag_q  (evt_q[i])
        );
    end

    // Interrupt output registered for a clean level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(evt_q & irq_en_q);
        end
    end

endmodule : ssc_top
`default_nettype wire

// file: pkg/ssc_pkg.sv
// Constants shared by the semaphore control block
package ssc_pkg;

    // Register byte offsets
    localparam logic [11:0] OFS_TASK_ACQUIRE   = 12'h024;
    localparam logic [11:0] OFS_TASK_RELEASE   = 12'h028;
    localparam logic [11:0] OFS_EVT_END        = 12'h104;
    localparam logic [11:0] OFS_EVT_RXFULL     = 12'h110;
    localparam logic [11:0] OFS_EVT_TAKEN      = 12'h128;
    localparam logic [11:0] OFS_SHORTCUT       = 12'h200;
    localparam logic [11:0] OFS_IRQ_EN_SET     = 12'h304;
    localparam logic [11:0] OFS_IRQ_EN_CLR     = 12'h308;
    localparam logic [11:0] OFS_SEM_STATE      = 12'h400;
    localparam logic [11:0] OFS_IRQ_STATUS     = 12'h600;
    localparam logic [11:0] OFS_IRQ_CLEAR      = 12'h604;

    // Event bit positions in enable, status and clear registers
    localparam int unsigned EVT_N              = 3;
    localparam int unsigned EVT_END_BIT        = 0;
    localparam int unsigned EVT_RXFULL_BIT     = 1;
    localparam int unsigned EVT_TAKEN_BIT      = 2;

    // Field positions
    localparam int unsigned TASK_BIT           = 0;
    localparam int unsigned SHORT_END_ACQ_BIT  = 0;

    // Reset values
    localparam logic [EVT_N-1:0] IRQ_EN_RESET  = 3'h0;
    localparam logic             SHORT_RESET   = 1'b0;

    // Semaphore state codes as read back
    localparam logic [1:0] SEM_CODE_FREE       = 2'h0;
    localparam logic [1:0] SEM_CODE_CPU        = 2'h1;
    localparam logic [1:0] SEM_CODE_SLAVE      = 2'h2;
    localparam logic [1:0] SEM_CODE_PEND       = 2'h3;

    // Receive buffer size in bytes and index of the last bit in a byte
    localparam logic [7:0] RX_BUF_BYTES        = 8'h04;
    localparam logic [2:0] BITS_LAST           = 3'h7;

    typedef enum logic [1:0] {
        SSC_FREE,
        SSC_CPU,
        SSC_SLAVE,
        SSC_PEND
    } ssc_sem_type;

endpackage : ssc_pkg

// file: logic/ssc_sync.sv
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module ssc_sync #(
    parameter int unsigned W = 3
) (
    // Clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // Data
    input  wire logic [W-1:0] d,
    output var  logic [W-1:0] q
);
    logic [W-1:0] meta_q;

    // First stage feeds only the second stage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= '0;
            q      <= '0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule : ssc_sync
`default_nettype wire

// file: logic/ssc_evt.sv
// Sticky event flag with set priority over clear
`timescale 1ns/1ps
`default_nettype none
module ssc_evt (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Control
    input  wire logic set,
    input  wire logic clr,
    output var  logic flag_q
);
    // A set in the clearing cycle must not be lost
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_q <= 1'b0;
        end else if (set) begin
            flag_q <= 1'b1;
        end else if (clr) begin
            flag_q <= 1'b0;
        end
    end
endmodule : ssc_evt
`default_nettype wire

// file: dv/ssc_props.sv
// Port checker for the semaphore control block
`timescale 1ns/1ps
`default_nettype none
module ssc_props
    import ssc_pkg::*;
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    // Interrupt
    input  wire logic        irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic mapped;
    assign mapped = paddr inside {OFS_TASK_ACQUIRE, OFS_TASK_RELEASE, OFS_EVT_END,
        OFS_EVT_RXFULL, OFS_EVT_TAKEN, OFS_SHORTCUT, OFS_IRQ_EN_SET, OFS_IRQ_EN_CLR,
        OFS_SEM_STATE, OFS_IRQ_STATUS, OFS_IRQ_CLEAR};
    sequence s_first;
        psel && $rose(penable);
    endsequence
    sequence s_done;
        psel && penable && pready;
    endsequence
    a_ready_second: assert property (s_first |=> pready)
        else $error("pready not in second access cycle");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_err_map: assert property (pready |-> (pslverr == !mapped))
        else $error("pslverr does not match address map");
    a_err_zero: assert property (pslverr |-> prdata == 32'h0000_0000)
        else $error("refused read data not zero");
    a_state_field: assert property (s_done ##0 (!pwrite && paddr == OFS_SEM_STATE) |->
        prdata[31:2] == 30'h0000_0000) else $error("state read has upper bits");
    a_task_zero: assert property (s_done ##0 (!pwrite && (paddr == OFS_TASK_RELEASE
        || paddr == OFS_TASK_ACQUIRE)) |-> prdata == 32'h0000_0000) else $error("task read");
    // Next enable write cannot land before this window closes
    a_irq_off: assert property (s_done ##0 (pwrite && paddr == OFS_IRQ_EN_CLR
        && pwdata[2:0] == 3'h7) |-> ##2 !irq [*2]) else $error("irq with enables cleared");
endmodule : ssc_props
bind ssc_top ssc_props i_ssc_props (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
`default_nettype wire

// file: dv/ssc_spi_master.sv
// External serial master model for the link pins
`timescale 1ns/1ps
`default_nettype none
module ssc_spi_master (
    // Link pins
    output var logic sck,
    output var logic csn_n,
    output var logic mosi
);
    initial begin
        sck   = 1'b0;
        csn_n = 1'b1;
        mosi  = 1'b0;
    end
    // Offset from pclk edges; clock stands still low between frames
    task start();
        #10 csn_n = 1'b0;
        #400;
    endtask : start
    task bits(input int n);
        for (int i = 0; i < n; i++) begin
            mosi = ~mosi;
            #400 sck = 1'b1;
            #400 sck = 1'b0;
        end
    endtask : bits
    task stop();
        #400 csn_n = 1'b1;
        // Deselected data line shows the inverse of its last value
        mosi = ~mosi;
    endtask : stop
endmodule : ssc_spi_master
`default_nettype wire

// file: dv/tb.sv
// Self-checking bench for the semaphore control block
`timescale 1ns/1ps
`default_nettype none
module tb;
    import ssc_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic        er, sck, csn_n, mosi;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, seed;
    logic [2:0]  en;
    int          err_total, samples_checked;
    ssc_top i_ssc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sck(sck), .csn_n(csn_n), .mosi(mosi),
        .irq(irq));
    ssc_spi_master i_ssc_spi_master (.sck(sck), .csn_n(csn_n), .mosi(mosi));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic logic [2:0] en_next(input logic [2:0] o, input logic [31:0] w,
                                           input logic set);
        return set ? (o | w[2:0]) : (o & ~w[2:0]);
    endfunction : en_next
    task test_done();
        $display("checked %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : test_done
    task chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    // Waits on pready with no assumed latency
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) err_total++;
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task rdchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd, e);
    endtask : rdchk
    task frame(input int n);
        i_ssc_spi_master.bits(n);
        i_ssc_spi_master.stop();
        repeat (8) @(posedge pclk);
    endtask : frame
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    initial begin
        #3_000_000;
        err_total++;
        test_done();
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {err_total, samples_checked, en, seed} = {64'd0, 3'h0, 32'h0000_f2d8};
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        rdchk(OFS_EVT_TAKEN, 32'h0000_0000);
        rdchk(OFS_SHORTCUT, 32'h0000_0000);
        rdchk(OFS_IRQ_EN_SET, 32'h0000_0000);
        rdchk(OFS_IRQ_EN_CLR, 32'h0000_0000);
        rdchk(OFS_SEM_STATE, 32'h0000_0001);
        apb(1'b0, 12'h3fc, 32'h0000_0000);
        chk({31'h0, er}, 32'h0000_0001);
        $display("reset test done");
        for (int i = 0; i < 10; i++) begin
            seed = lfsr(seed);
            wr(seed[8] ? OFS_IRQ_EN_SET : OFS_IRQ_EN_CLR, seed);
            en = en_next(en, seed, seed[8]);
            rdchk(OFS_IRQ_EN_SET, {29'h0, en});
            rdchk(OFS_IRQ_EN_CLR, {29'h0, en});
        end
        wr(OFS_IRQ_EN_CLR, 32'h0000_0007);
        wr(OFS_IRQ_EN_SET, 32'h0000_0004);
        wr(OFS_TASK_RELEASE, 32'h0000_0001);
        rdchk(OFS_SEM_STATE, 32'h0000_0000);
        chk({31'h0, irq}, 32'h0000_0000);
        wr(OFS_TASK_ACQUIRE, 32'h0000_0001);
        rdchk(OFS_SEM_STATE, 32'h0000_0001);
        rdchk(OFS_EVT_TAKEN, 32'h0000_0001);
        chk({31'h0, irq}, 32'h0000_0001);
        wr(OFS_IRQ_EN_CLR, 32'h0000_0004);
        rdchk(OFS_IRQ_EN_SET, 32'h0000_0000);
        chk({31'h0, irq}, 32'h0000_0000);
        wr(OFS_EVT_TAKEN, 32'h0000_0000);
        rdchk(OFS_EVT_TAKEN, 32'h0000_0000);
        $display("ownership test done");
        wr(OFS_TASK_RELEASE, 32'h0000_0001);
        i_ssc_spi_master.start();
        repeat (8) @(posedge pclk);
        rdchk(OFS_SEM_STATE, 32'h0000_0002);
        wr(OFS_TASK_ACQUIRE, 32'h0000_0001);
        rdchk(OFS_SEM_STATE, 32'h0000_0003);
        i_ssc_spi_master.bits(32);
        rdchk(OFS_EVT_RXFULL, 32'h0000_0001);
        frame(0);
        rdchk(OFS_SEM_STATE, 32'h0000_0001);
        rdchk(OFS_EVT_TAKEN, 32'h0000_0001);
        wr(OFS_IRQ_EN_SET, 32'h0000_0007);
        rdchk(OFS_IRQ_STATUS, 32'h0000_0007);
        chk({31'h0, irq}, 32'h0000_0001);
        wr(OFS_IRQ_EN_CLR, 32'h0000_0007);
        rdchk(OFS_EVT_END, 32'h0000_0001);
        chk({31'h0, irq}, 32'h0000_0000);
        wr(OFS_IRQ_CLEAR, 32'h0000_0007);
        rdchk(OFS_IRQ_STATUS, 32'h0000_0000);
        $display("handover test done");
        for (int s = 0; s < 2; s++) begin
            wr(OFS_EVT_TAKEN, 32'h0000_0000);
            wr(OFS_SHORTCUT, 32'(s));
            wr(OFS_TASK_RELEASE, 32'h0000_0001);
            i_ssc_spi_master.start();
            frame(8);
            rdchk(OFS_SEM_STATE, 32'(s));
            rdchk(OFS_EVT_TAKEN, 32'(s));
        end
        $display("shortcut test done");
        test_done();
    end
endmodule : tb
`default_nettype wire
